/* File: include/fcl_consts.vh */
`ifndef FCL_CONSTS_VH
`define FCL_CONSTS_VH

// Register offsets, fuse bytes first
`define FCL_OFS_WDT 8'h00
`define FCL_OFS_BOD 8'h01
`define FCL_OFS_OSC 8'h02
`define FCL_OFS_SYS0 8'h05
`define FCL_OFS_SYS1 8'h06
`define FCL_OFS_APP_END 8'h07
`define FCL_OFS_BOOT_END 8'h08
`define FCL_OFS_CAL_A 8'h10
`define FCL_OFS_CAL_B 8'h11
`define FCL_OFS_STATUS 8'h12

// Shadow slot of each fuse byte, in read order
`define FCL_IX_WDT 3'h0
`define FCL_IX_BOD 3'h1
`define FCL_IX_OSC 3'h2
`define FCL_IX_SYS0 3'h3
`define FCL_IX_SYS1 3'h4
`define FCL_IX_APP_END 3'h5
`define FCL_IX_BOOT_END 3'h6
`define FCL_IX_LAST 3'h6

// Fuse field positions
`define FCL_WDT_WINDOW 7:4
`define FCL_WDT_PERIOD 3:0
`define FCL_BOD_LEVEL 7:5
`define FCL_BOD_SAMPLE 4
`define FCL_BOD_ACTIVE 3:2
`define FCL_BOD_SLEEP 1:0
`define FCL_OSC_LOCK 7
`define FCL_OSC_FREQ 1:0
`define FCL_SYS0_CRC 7:6
`define FCL_SYS0_RPIN 3:2
`define FCL_SYS0_EEKEEP 0
`define FCL_SYS1_STARTUP 2:0
`define FCL_CALB_LOCK 7
`define FCL_CALB_TEMP 3:0

// Reset values of the fuse shadows and calibration registers before the first load
`define FCL_RST_WDT 8'h00
`define FCL_RST_BOD 8'h00
`define FCL_RST_OSC 8'h02
`define FCL_RST_SYS0 8'hC4
`define FCL_RST_SYS1 8'h07
`define FCL_RST_APP_END 8'h00
`define FCL_RST_BOOT_END 8'h00
`define FCL_RST_CAL_A 8'h00
`define FCL_RST_CAL_T 4'h0

// Encodings
`define FCL_BOD_THR_LOW 3'h0
`define FCL_BOD_THR_MID 3'h2
`define FCL_BOD_THR_HIGH 3'h7
`define FCL_BOD_SAMP_1KHZ 1'b0
`define FCL_BOD_SAMP_125HZ 1'b1
`define FCL_BOD_MODE_OFF 2'h0
`define FCL_BOD_MODE_ON 2'h1
`define FCL_BOD_MODE_SAMPLED 2'h2
`define FCL_BOD_MODE_ON_WAIT 2'h3
`define FCL_FREQ_16M 2'h1
`define FCL_FREQ_20M 2'h2
`define FCL_CRC_FLASH 2'h0
`define FCL_CRC_BOOT 2'h1
`define FCL_CRC_BOOT_APP 2'h2
`define FCL_CRC_NONE 2'h3
`define FCL_RPIN_GPIO 2'h0
`define FCL_RPIN_DEBUG 2'h1
`define FCL_RPIN_RESET 2'h2

// Flash boundaries and timing
`define FCL_BLOCK_PAD 8'h00
`define FCL_FLASH_BYTES 16'h4000
`define FCL_CLK_KHZ 24'h01E848
`define FCL_STARTUP_UNIT_MS 24'h000001
`define FCL_STARTUP_BASE_MS 7'h01
`define FCL_PIN_HOLD_SLOW 10'h300

`endif

/* File: rtl/fcl_loader.v */
// Operation
// RULE1: Watchdog fuse bits 7:4 load the watchdog window time-out field at reset.
// RULE2: Watchdog fuse bits 3:0 load the watchdog normal period field at reset.
// RULE3: Brown-out settings reload only after power-on reset; other resets keep them.
// RULE4: Brown-out level bits 7:5 load control B; 0, 2, 7 low/mid/high.
// RULE5: Sample-rate bit loads control A; zero 1 kHz, one 125 Hz.
// RULE6: Active mode field: off, on, sampled, on with wake held until ready.
// RULE7: Sleep mode field from bits 1:0: off, on, sampled, code 3 reserved.
// RULE8: Oscillator lock bit loads calibration B lock; one blocks calibration writes.
// RULE9: Frequency select picks 16 or 20 MHz and matching factory calibration.
// RULE10: CRC source: whole flash, boot, boot plus app code, or no scan.
// RULE11: Reset pin function: GPIO, debug interface, reset input, code 3 reserved.
// RULE12: GPIO reset pin driver stays off 768 slow oscillator cycles after reset.
// RULE13: Software enables reset pin interrupts only after that hold interval.
// RULE14: Chip erase keeps EEPROM if keep bit set, unless device locked.
// RULE15: Start-up field gives 0,1,2,4,8,16,32,64 ms before code runs. Here the delay applies only to power-on loads; other resets start code at once.
// RULE16: Application end fuse marks app code end in 256-byte blocks.
// RULE17: Application end is programmed as boot size plus app code size.
// RULE18: Application end zero makes boot end through flash end app code.
// RULE19: Both application and boot end zero make whole flash boot section.
// RULE20: Boot end fuse marks boot section end in 256-byte blocks.
// RULE21: Fuse fields are sampled once per qualifying reset and then held.
// RULE22: Fuse bytes are read-only; software writes change nothing loaded.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "fcl_consts.vh"

module fcl_loader #(
   parameter [23:0] MS_CYCLES = `FCL_CLK_KHZ * `FCL_STARTUP_UNIT_MS,
   parameter [15:0] FLASH_BYTES = `FCL_FLASH_BYTES
) (
   input wire clk_in,
   input wire rst_b_in,
   input wire sys_rst_in,
   input wire rst_is_por_in,
   input wire slow_osc_clk_in,
   output reg fuse_rd_out,
   output reg [7:0] fuse_addr_out,
   input wire [7:0] fuse_data_in,
   input wire [7:0] fact_cal16_in,
   input wire [3:0] fact_temp16_in,
   input wire [7:0] fact_cal20_in,
   input wire [3:0] fact_temp20_in,
   input wire chip_erase_in,
   input wire device_locked_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [7:0] reg_rdata_out,
   output reg [3:0] wdt_window_out,
   output reg [3:0] wdt_period_out,
   output reg [2:0] brownout_threshold_level_out,
   output reg brownout_sample_rate_out,
   output reg [1:0] bod_active_mode_out,
   output reg [1:0] bod_sleep_mode_out,
   output reg osc_calibration_lock_out,
   output reg [1:0] osc_frequency_select_out,
   output reg [7:0] fast_osc_calibration_value_out,
   output reg [3:0] fast_osc_temp_calibration_out,
   output reg [1:0] crc_scan_source_out,
   output reg crc_scan_enable_out,
   output reg [15:0] crc_scan_end_out,
   output reg [1:0] reset_pin_function_out,
   output reg gpio_drive_allow_out,
   output reg eeprom_erase_out,
   output reg [15:0] boot_end_addr_out,
   output reg [15:0] app_end_addr_out,
   output reg cpu_run_out
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_READ = 3'h1;
   localparam [2:0] ST_CAPT = 3'h2;
   localparam [2:0] ST_APPLY = 3'h3;
   localparam [2:0] ST_HOLD = 3'h4;
   localparam [2:0] ST_DELAY = 3'h5;
   localparam [2:0] ST_RUN = 3'h6;

   reg [2:0] state_r;
   reg [2:0] idx_r;
   reg [7:0] fuse_r [0:6];
   reg por_pending_r;
   reg por_load_r;
   reg [6:0] delay_ms_r;
   reg [6:0] ms_done_r;
   reg [23:0] ms_cnt_r;
   reg slow_s1_r;
   reg slow_s2_r;
   reg slow_s3_r;
   reg [9:0] pin_hold_cnt_r;
   reg [7:0] cal_a_r;
   reg [3:0] cal_t_r;
   reg [15:0] boot_end_nxt;
   reg [15:0] app_end_nxt;
   reg [15:0] crc_end_nxt;

   wire [7:0] wdt_f = fuse_r[`FCL_IX_WDT];
   wire [7:0] bod_f = fuse_r[`FCL_IX_BOD];
   wire [7:0] osc_f = fuse_r[`FCL_IX_OSC];
   wire [7:0] sys0_f = fuse_r[`FCL_IX_SYS0];
   wire [7:0] sys1_f = fuse_r[`FCL_IX_SYS1];
   wire [7:0] app_end_f = fuse_r[`FCL_IX_APP_END];
   wire [7:0] boot_end_f = fuse_r[`FCL_IX_BOOT_END];
   wire apply_w = (state_r == ST_APPLY);
   wire slow_rise_w = slow_s2_r & ~slow_s3_r;
   wire start_w = sys_rst_in & ((state_r == ST_IDLE) | (state_r == ST_RUN));

   // Fuse offset fetched for each shadow slot
   function [7:0] fuse_ofs;
      input [2:0] ix;
      begin
         case (ix)
            `FCL_IX_WDT: fuse_ofs = `FCL_OFS_WDT;
            `FCL_IX_BOD: fuse_ofs = `FCL_OFS_BOD;
            `FCL_IX_OSC: fuse_ofs = `FCL_OFS_OSC;
            `FCL_IX_SYS0: fuse_ofs = `FCL_OFS_SYS0;
            `FCL_IX_SYS1: fuse_ofs = `FCL_OFS_SYS1;
            `FCL_IX_APP_END: fuse_ofs = `FCL_OFS_APP_END;
            default: fuse_ofs = `FCL_OFS_BOOT_END;
         endcase
      end
   endfunction

   // Start-up delay in ms: zero, else doubling from one
   function [6:0] startup_ms;
      input [2:0] code;
      begin
         if (code == 3'h0) begin
            startup_ms = 7'h00;
         end else begin
            startup_ms = `FCL_STARTUP_BASE_MS << (code - 3'h1); // see RULE15
         end
      end
   endfunction

   // Load sequencer: fetch every fuse byte once per system reset that arrives in idle or run
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_r <= ST_IDLE;
         idx_r <= 3'h0;
         fuse_rd_out <= 1'b0;
         fuse_addr_out <= 8'h00;
         por_pending_r <= 1'b1;
         por_load_r <= 1'b0;
         cpu_run_out <= 1'b0;
         delay_ms_r <= 7'h00;
         ms_done_r <= 7'h00;
         ms_cnt_r <= 24'h000000;
      end else begin
         case (state_r)
            ST_IDLE, ST_RUN: begin
               if (start_w) begin
                  state_r <= ST_READ;
                  idx_r <= 3'h0;
                  cpu_run_out <= 1'b0;
                  por_load_r <= rst_is_por_in | por_pending_r; // see RULE3
               end
            end
            ST_READ: begin
               fuse_rd_out <= 1'b1;
               fuse_addr_out <= fuse_ofs(idx_r);
               state_r <= ST_CAPT;
            end
            ST_CAPT: begin
               fuse_rd_out <= 1'b0;
               if (idx_r == `FCL_IX_LAST) begin
                  state_r <= ST_APPLY;
               end else begin
                  idx_r <= idx_r + 3'h1;
                  state_r <= ST_READ;
               end
            end
            ST_APPLY: begin
               por_pending_r <= 1'b0;
               delay_ms_r <= startup_ms(sys1_f[`FCL_SYS1_STARTUP]); // see RULE15
               state_r <= ST_HOLD;
            end
            ST_HOLD: begin
               ms_cnt_r <= 24'h000000;
               ms_done_r <= 7'h00;
               if (!sys_rst_in) begin
                  if (por_load_r && (delay_ms_r != 7'h00)) begin
                     state_r <= ST_DELAY;
                  end else begin
                     state_r <= ST_RUN;
                     cpu_run_out <= 1'b1;
                  end
               end
            end
            ST_DELAY: begin
               // Power-on start-up time counted in whole milliseconds
               if (sys_rst_in) begin
                  state_r <= ST_HOLD;
               end else if (ms_cnt_r == MS_CYCLES - 24'h000001) begin
                  ms_cnt_r <= 24'h000000;
                  if (ms_done_r + 7'h01 == delay_ms_r) begin
                     state_r <= ST_RUN;
                     cpu_run_out <= 1'b1; // see RULE15
                  end else begin
                     ms_done_r <= ms_done_r + 7'h01;
                  end
               end else begin
                  ms_cnt_r <= ms_cnt_r + 24'h000001;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Fuse shadows: written only by the loader, never by the bus
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         fuse_r[`FCL_IX_WDT] <= `FCL_RST_WDT;
         fuse_r[`FCL_IX_BOD] <= `FCL_RST_BOD;
         fuse_r[`FCL_IX_OSC] <= `FCL_RST_OSC;
         fuse_r[`FCL_IX_SYS0] <= `FCL_RST_SYS0;
         fuse_r[`FCL_IX_SYS1] <= `FCL_RST_SYS1;
         fuse_r[`FCL_IX_APP_END] <= `FCL_RST_APP_END;
         fuse_r[`FCL_IX_BOOT_END] <= `FCL_RST_BOOT_END;
      end else if (state_r == ST_CAPT) begin
         fuse_r[idx_r] <= fuse_data_in; // see RULE21
      end
   end

   // Watchdog, oscillator and system fields follow every load
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         wdt_window_out <= 4'h0;
         wdt_period_out <= 4'h0;
         osc_calibration_lock_out <= 1'b0;
         osc_frequency_select_out <= `FCL_FREQ_20M;
         crc_scan_source_out <= `FCL_CRC_NONE;
         reset_pin_function_out <= `FCL_RPIN_RESET;
         boot_end_addr_out <= FLASH_BYTES;
         app_end_addr_out <= FLASH_BYTES;
         crc_scan_end_out <= 16'h0000;
         crc_scan_enable_out <= 1'b0;
      end else if (apply_w) begin
         wdt_window_out <= wdt_f[`FCL_WDT_WINDOW]; // see RULE1
         wdt_period_out <= wdt_f[`FCL_WDT_PERIOD]; // see RULE2
         osc_calibration_lock_out <= osc_f[`FCL_OSC_LOCK]; // see RULE8
         osc_frequency_select_out <= osc_f[`FCL_OSC_FREQ]; // see RULE9
         crc_scan_source_out <= sys0_f[`FCL_SYS0_CRC]; // see RULE10
         reset_pin_function_out <= sys0_f[`FCL_SYS0_RPIN]; // see RULE11
         boot_end_addr_out <= boot_end_nxt;
         app_end_addr_out <= app_end_nxt;
         crc_scan_end_out <= crc_end_nxt;
         crc_scan_enable_out <= (sys0_f[`FCL_SYS0_CRC] != `FCL_CRC_NONE); // see RULE10
      end
   end

   // Section boundaries in bytes from 256-byte block counts
   always @* begin
      boot_end_nxt = {boot_end_f, `FCL_BLOCK_PAD}; // see RULE20
      app_end_nxt = {app_end_f, `FCL_BLOCK_PAD}; // see RULE16
      if (boot_end_f == 8'h00) begin
         boot_end_nxt = FLASH_BYTES; // see RULE19
      end
      if (app_end_f == 8'h00) begin
         app_end_nxt = FLASH_BYTES; // see RULE18
      end
      case (sys0_f[`FCL_SYS0_CRC])
         `FCL_CRC_FLASH: crc_end_nxt = FLASH_BYTES;
         `FCL_CRC_BOOT: crc_end_nxt = boot_end_nxt;
         `FCL_CRC_BOOT_APP: crc_end_nxt = app_end_nxt;
         default: crc_end_nxt = 16'h0000;
      endcase
   end

   // Brown-out fields only move on a power-on load
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         brownout_threshold_level_out <= `FCL_BOD_THR_LOW;
         brownout_sample_rate_out <= `FCL_BOD_SAMP_1KHZ;
         bod_active_mode_out <= `FCL_BOD_MODE_OFF;
         bod_sleep_mode_out <= `FCL_BOD_MODE_OFF;
      end else if (apply_w && por_load_r) begin // see RULE3
         brownout_threshold_level_out <= bod_f[`FCL_BOD_LEVEL]; // see RULE4
         brownout_sample_rate_out <= bod_f[`FCL_BOD_SAMPLE]; // see RULE5
         bod_active_mode_out <= bod_f[`FCL_BOD_ACTIVE]; // see RULE6
         bod_sleep_mode_out <= bod_f[`FCL_BOD_SLEEP]; // see RULE7
      end
   end

   // Calibration: factory values on load, software writes unless locked
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         cal_a_r <= `FCL_RST_CAL_A;
         cal_t_r <= `FCL_RST_CAL_T;
      end else if (apply_w) begin
         if (osc_f[`FCL_OSC_FREQ] == `FCL_FREQ_16M) begin
            cal_a_r <= fact_cal16_in; // see RULE9
            cal_t_r <= fact_temp16_in;
         end else begin
            cal_a_r <= fact_cal20_in; // see RULE9
            cal_t_r <= fact_temp20_in;
         end
      end else if (reg_wr_in && !osc_calibration_lock_out) begin // see RULE8
         if (reg_addr_in == `FCL_OFS_CAL_A) begin
            cal_a_r <= reg_wdata_in;
         end else if (reg_addr_in == `FCL_OFS_CAL_B) begin
            cal_t_r <= reg_wdata_in[`FCL_CALB_TEMP];
         end
      end
   end

   // Calibration outputs mirror the working registers
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         fast_osc_calibration_value_out <= `FCL_RST_CAL_A;
         fast_osc_temp_calibration_out <= `FCL_RST_CAL_T;
      end else begin
         fast_osc_calibration_value_out <= cal_a_r;
         fast_osc_temp_calibration_out <= cal_t_r;
      end
   end

   // Slow oscillator brought in by two flops, third for edge detect
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         slow_s1_r <= 1'b0;
         slow_s2_r <= 1'b0;
         slow_s3_r <= 1'b0;
      end else begin
         slow_s1_r <= slow_osc_clk_in;
         slow_s2_r <= slow_s1_r;
         slow_s3_r <= slow_s2_r;
      end
   end

   // Reset pin driver hold: restarts with each system reset
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         pin_hold_cnt_r <= 10'h000;
         gpio_drive_allow_out <= 1'b0;
      end else if (sys_rst_in || (state_r != ST_DELAY && state_r != ST_RUN)) begin
         pin_hold_cnt_r <= 10'h000;
         gpio_drive_allow_out <= 1'b0; // see RULE12
      end else begin
         if (slow_rise_w && pin_hold_cnt_r != `FCL_PIN_HOLD_SLOW) begin
            pin_hold_cnt_r <= pin_hold_cnt_r + 10'h001;
         end
         gpio_drive_allow_out <= (reset_pin_function_out == `FCL_RPIN_GPIO) &&
            (pin_hold_cnt_r == `FCL_PIN_HOLD_SLOW); // see RULE12
      end
   end

   // Chip erase decides EEPROM fate from keep bit and lock state
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         eeprom_erase_out <= 1'b0;
      end else begin
         eeprom_erase_out <= chip_erase_in &
            (device_locked_in | ~sys0_f[`FCL_SYS0_EEKEEP]); // see RULE14
      end
   end

   // Register read port; fuse bytes ignore writes
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         if (reg_addr_in == `FCL_OFS_WDT) begin
            reg_rdata_out <= wdt_f; // see RULE22
         end else if (reg_addr_in == `FCL_OFS_BOD) begin
            reg_rdata_out <= bod_f;
         end else if (reg_addr_in == `FCL_OFS_OSC) begin
            reg_rdata_out <= osc_f;
         end else if (reg_addr_in == `FCL_OFS_SYS0) begin
            reg_rdata_out <= sys0_f;
         end else if (reg_addr_in == `FCL_OFS_SYS1) begin
            reg_rdata_out <= sys1_f;
         end else if (reg_addr_in == `FCL_OFS_APP_END) begin
            reg_rdata_out <= app_end_f;
         end else if (reg_addr_in == `FCL_OFS_BOOT_END) begin
            reg_rdata_out <= boot_end_f;
         end else if (reg_addr_in == `FCL_OFS_CAL_A) begin
            reg_rdata_out <= cal_a_r;
         end else if (reg_addr_in == `FCL_OFS_CAL_B) begin
            reg_rdata_out <= {osc_calibration_lock_out, 3'h0, cal_t_r};
         end else if (reg_addr_in == `FCL_OFS_STATUS) begin
            reg_rdata_out <= {4'h0, gpio_drive_allow_out, por_pending_r,
               cpu_run_out, (state_r != ST_IDLE && state_r != ST_RUN)};
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

endmodule

/* File: bench/fcl_loader_props.sv */
`timescale 1ns/1ps
module fcl_loader_props (
   input wire clk_in,
   input wire rst_b_in,
   input wire sys_rst_in,
   input wire rst_is_por_in,
   input wire chip_erase_in,
   input wire device_locked_in,
   input wire reg_rd_in,
   input wire fuse_rd_out,
   input wire [7:0] fuse_addr_out,
   input wire [7:0] reg_rdata_out,
   input wire [3:0] wdt_window_out,
   input wire [3:0] wdt_period_out,
   input wire [2:0] brownout_threshold_level_out,
   input wire [1:0] crc_scan_source_out,
   input wire crc_scan_enable_out,
   input wire [1:0] reset_pin_function_out,
   input wire gpio_drive_allow_out,
   input wire eeprom_erase_out,
   input wire cpu_run_out
);
   reg loaded_r;
   default clocking dcb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // Notes that a first load has run, so later loads may be warm resets
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         loaded_r <= 1'b0;
      end else if (fuse_rd_out) begin
         loaded_r <= 1'b1;
      end
   end
   property p_rd_idle;
      !reg_rd_in |=> reg_rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
   property p_erase_locked;
      chip_erase_in && device_locked_in |=> eeprom_erase_out;
   endproperty
   a_erase_locked: assert property (p_erase_locked) else $error("locked erase kept data");
   property p_erase_idle;
      !chip_erase_in |=> !eeprom_erase_out;
   endproperty
   a_erase_idle: assert property (p_erase_idle) else $error("erase without request");
   property p_crc_enable;
      crc_scan_enable_out == (crc_scan_source_out != 2'h3);
   endproperty
   a_crc_enable: assert property (p_crc_enable) else $error("scan enable wrong");
   property p_pin_gpio;
      gpio_drive_allow_out |-> reset_pin_function_out == 2'h0;
   endproperty
   a_pin_gpio: assert property (p_pin_gpio) else $error("drive allowed off GPIO");
   property p_pin_hold;
      sys_rst_in [*3] |=> !gpio_drive_allow_out;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("drive allowed in reset");
   property p_run_stop;
      sys_rst_in ##1 sys_rst_in |=> !cpu_run_out;
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("code runs in reset");
   property p_fuse_order;
      fuse_rd_out && fuse_addr_out == 8'h00 |-> ##2 fuse_rd_out && fuse_addr_out == 8'h01
         ##2 fuse_rd_out && fuse_addr_out == 8'h02 ##2 fuse_rd_out && fuse_addr_out == 8'h05;
   endproperty
   a_fuse_order: assert property (p_fuse_order) else $error("fuse read order");
   property p_hold_fields;
      !fuse_rd_out [*8] |=> $stable({wdt_window_out, wdt_period_out});
   endproperty
   a_hold_fields: assert property (p_hold_fields) else $error("field moved");
   property p_bod_keep;
      $rose(sys_rst_in) && !rst_is_por_in && loaded_r |-> ##20
         brownout_threshold_level_out == $past(brownout_threshold_level_out, 20);
   endproperty
   a_bod_keep: assert property (p_bod_keep) else $error("brown-out reloaded");
   // Main scenarios
   c_load: cover property (fuse_rd_out && fuse_addr_out == 8'h08);
   c_erase: cover property (eeprom_erase_out);
   c_pin: cover property (gpio_drive_allow_out);
endmodule

/* File: bench/fcl_fuse_model.sv */
`timescale 1ns/1ps
module fcl_fuse_model (
   input wire clk_in,
   input wire rd_in,
   input wire [7:0] addr_in,
   output reg [7:0] data_out
);
   reg [7:0] mem [0:15];
   initial data_out = 8'h00;
   // Byte stands from mid-cycle while the strobe is high, so the loader
   // captures it at the next rising edge; an idle bus shows the inverse
   always @(negedge clk_in) begin
      if (rd_in) begin
         data_out <= mem[addr_in[3:0]];
      end else begin
         data_out <= ~mem[addr_in[3:0]];
      end
   end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "fcl_consts.vh"
module tb;
   reg clk_in = 1'b0;
   reg slow_osc_clk_in = 1'b0;
   reg rst_b_in = 1'b0;
   reg sys_rst_in = 1'b0;
   reg rst_is_por_in = 1'b0;
   reg chip_erase_in = 1'b0;
   reg device_locked_in = 1'b0;
   reg [7:0] reg_addr_in = 8'h00;
   reg [7:0] reg_wdata_in = 8'h00;
   reg reg_wr_in = 1'b0;
   reg reg_rd_in = 1'b0;
   integer bad_count = 0;
   integer check_count = 0;
   integer cycles = 0;
   wire fuse_rd_out, brownout_sample_rate_out, osc_calibration_lock_out, crc_scan_enable_out;
   wire gpio_drive_allow_out, eeprom_erase_out, cpu_run_out;
   wire [7:0] fuse_addr_out, fuse_data_in, reg_rdata_out, fast_osc_calibration_value_out;
   wire [3:0] wdt_window_out, wdt_period_out, fast_osc_temp_calibration_out;
   wire [2:0] brownout_threshold_level_out;
   wire [1:0] bod_active_mode_out, bod_sleep_mode_out, osc_frequency_select_out;
   wire [1:0] crc_scan_source_out, reset_pin_function_out;
   wire [15:0] crc_scan_end_out, boot_end_addr_out, app_end_addr_out;
   // Grouped views of the loaded fields
   wire [7:0] wdt_w = {wdt_window_out, wdt_period_out};
   wire [7:0] bod_w = {brownout_threshold_level_out, brownout_sample_rate_out,
      bod_active_mode_out, bod_sleep_mode_out};
   wire [2:0] osc_w = {osc_calibration_lock_out, osc_frequency_select_out};
   wire [11:0] cal_w = {fast_osc_calibration_value_out, fast_osc_temp_calibration_out};
   wire [4:0] sys_w = {crc_scan_source_out, crc_scan_enable_out, reset_pin_function_out};
   wire [31:0] ends_w = {boot_end_addr_out, app_end_addr_out};
   // System clock and an unrelated slow oscillator
   always #4 clk_in = ~clk_in;
   always #20.3 slow_osc_clk_in = ~slow_osc_clk_in;
   fcl_loader #(.MS_CYCLES(24'h000004)) u_fcl_loader (
      .clk_in, .rst_b_in, .sys_rst_in, .rst_is_por_in, .slow_osc_clk_in,
      .fuse_rd_out, .fuse_addr_out, .fuse_data_in,
      .fact_cal16_in(8'h3C), .fact_temp16_in(4'h5), .fact_cal20_in(8'hA7), .fact_temp20_in(4'h9),
      .chip_erase_in, .device_locked_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .wdt_window_out, .wdt_period_out, .brownout_threshold_level_out,
      .brownout_sample_rate_out, .bod_active_mode_out, .bod_sleep_mode_out,
      .osc_calibration_lock_out, .osc_frequency_select_out, .fast_osc_calibration_value_out,
      .fast_osc_temp_calibration_out, .crc_scan_source_out, .crc_scan_enable_out,
      .crc_scan_end_out, .reset_pin_function_out, .gpio_drive_allow_out, .eeprom_erase_out,
      .boot_end_addr_out, .app_end_addr_out, .cpu_run_out
   );
   fcl_fuse_model u_fcl_fuse_model (
      .clk_in(clk_in), .rd_in(fuse_rd_out), .addr_in(fuse_addr_out), .data_out(fuse_data_in)
   );
   task summarize;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk_in);
         #1;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         reg_rd_in <= 1'b1;
         reg_addr_in <= a;
         cyc(1);
         reg_rd_in <= 1'b0;
         chk(reg_rdata_out, e);
         cyc(1);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         reg_wr_in <= 1'b1;
         reg_addr_in <= a;
         reg_wdata_in <= d;
         cyc(1);
         reg_wr_in <= 1'b0;
         cyc(1);
      end
   endtask
   task er(input lk, input e);
      begin
         device_locked_in <= lk;
         chip_erase_in <= 1'b1;
         cyc(1);
         chip_erase_in <= 1'b0;
         chk(eeprom_erase_out, e);
         cyc(1);
      end
   endtask
   // Program fuse bytes 0..8 (low byte first), then run one system reset
   task ld(input por, input [71:0] f);
      integer i;
      begin
         for (i = 0; i < 9; i = i + 1) begin
            u_fcl_fuse_model.mem[i] = f[8*i +: 8];
         end
         sys_rst_in <= 1'b1;
         rst_is_por_in <= por;
         cyc(20);
         sys_rst_in <= 1'b0;
         rst_is_por_in <= 1'b0;
         cyc(1);
      end
   endtask
   // Hang guard
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         summarize;
      end
   end
   // Test sequence
   initial begin
      cyc(8);
      rst_b_in <= 1'b1;
      cyc(2);
      ld(1'b1, 72'h08_20_03_80_00_00_81_E6_A5);
      cyc(8);
      chk(cpu_run_out, 1'b0);
      cyc(22);
      chk(cpu_run_out, 1'b1);
      chk(wdt_w, 8'hA5);
      chk(bod_w, 8'hE6);
      chk(osc_w, 3'h5);
      chk(cal_w, 12'h3C5);
      chk(sys_w, 5'h14);
      chk(crc_scan_end_out, 16'h2000);
      chk(ends_w, 32'h0800_2000);
      rd(8'h05, 8'h80);
      rd(8'h0C, 8'h00);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'hA5);
      wr(8'h10, 8'h77);
      rd(8'h10, 8'h3C);
      rd(8'h11, 8'h85);
      u_fcl_fuse_model.mem[0] = 8'h11;
      cyc(4);
      chk(wdt_w, 8'hA5);
      er(1'b0, 1'b1);
      er(1'b1, 1'b1);
      cyc(3000);
      chk(gpio_drive_allow_out, 1'b0);
      cyc(1000);
      chk(gpio_drive_allow_out, 1'b1);
      rd(8'h12, 8'h0A);
      // Pin interrupts would be enabled only from here
      $display("test 1 done");
      ld(1'b0, 72'h04_00_07_C5_00_00_02_00_3C);
      cyc(2);
      chk(cpu_run_out, 1'b1);
      chk(wdt_w, 8'h3C);
      chk(bod_w, 8'hE6);
      chk(osc_w, 3'h2);
      chk(cal_w, 12'hA79);
      chk(sys_w, 5'h19);
      chk(crc_scan_end_out, 16'h0000);
      chk(ends_w, {16'h0400, `FCL_FLASH_BYTES});
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h5A);
      wr(8'h11, 8'h03);
      rd(8'h11, 8'h03);
      er(1'b0, 1'b0);
      er(1'b1, 1'b1);
      $display("test 2 done");
      ld(1'b1, 72'h00_00_00_44_00_00_01_5B_00);
      cyc(2);
      chk(cpu_run_out, 1'b1);
      chk(bod_w, 8'h5B);
      chk(osc_w, 3'h1);
      chk(sys_w, 5'h0D);
      chk(ends_w, {`FCL_FLASH_BYTES, `FCL_FLASH_BYTES});
      $display("test 3 done");
      ld(1'b1, 72'h10_30_07_08_00_00_03_0D_F0);
      cyc(200);
      chk(cpu_run_out, 1'b0);
      cyc(100);
      chk(cpu_run_out, 1'b1);
      chk(bod_w, 8'h0D);
      chk(cal_w, 12'hA79);
      chk(sys_w, 5'h06);
      chk(crc_scan_end_out, `FCL_FLASH_BYTES);
      chk(ends_w, 32'h1000_3000);
      $display("test 4 done");
      summarize;
   end
endmodule
bind fcl_loader fcl_loader_props u_fcl_loader_props (
   .clk_in, .rst_b_in, .sys_rst_in, .rst_is_por_in, .chip_erase_in, .device_locked_in,
   .reg_rd_in, .fuse_rd_out, .fuse_addr_out, .reg_rdata_out, .wdt_window_out, .wdt_period_out,
   .brownout_threshold_level_out, .crc_scan_source_out, .crc_scan_enable_out,
   .reset_pin_function_out, .gpio_drive_allow_out, .eeprom_erase_out, .cpu_run_out
);
